/* File: hw/dpr_pkg.sv */
// Shared constants for the dual-port register store
package dpr_pkg;
  localparam int unsigned ADDR_W     = 9;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned HOLD_COUNT = 500;
  localparam int unsigned REG_COUNT  = 504;
  localparam int unsigned CFG_COUNT  = 4;

  localparam logic [ADDR_W-1:0] STATION_OFS = 9'h1f4;
  localparam logic [ADDR_W-1:0] SPEED_OFS   = 9'h1f5;
  localparam logic [ADDR_W-1:0] PARITY_OFS  = 9'h1f6;
  localparam logic [ADDR_W-1:0] STOP_OFS    = 9'h1f7;
  localparam logic [ADDR_W-1:0] LAST_OFS    = 9'h1f7;

  localparam logic [DATA_W-1:0] HOLD_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_NONE  = 16'h0000;

  // Index order: station, line speed, parity, stop bits
  localparam int unsigned CFG_STATION = 0;
  localparam int unsigned CFG_SPEED   = 1;
  localparam int unsigned CFG_PARITY  = 2;
  localparam int unsigned CFG_STOP    = 3;
  localparam logic [DATA_W-1:0] CFG_DEF [CFG_COUNT] =
    '{16'h0001, 16'h0071, 16'h007a, 16'h0083};
  localparam logic [DATA_W-1:0] CFG_MIN [CFG_COUNT] =
    '{16'h0001, 16'h006e, 16'h0078, 16'h0083};
  localparam logic [DATA_W-1:0] CFG_MAX [CFG_COUNT] =
    '{16'h00f7, 16'h0073, 16'h007a, 16'h0084};

  localparam logic [6:0] I2C_TARGET_ADDR = 7'h11;
endpackage : dpr_pkg

/* File: hw/dpr_cfg_word.sv */
// One range-checked configuration word with load and save strobe
`timescale 1ns/1ps
`default_nettype none
module dpr_cfg_word
  import dpr_pkg::*;
#(
  parameter logic [DATA_W-1:0] DEF  = 16'h0000,
  parameter logic [DATA_W-1:0] MINV = 16'h0000,
  parameter logic [DATA_W-1:0] MAXV = 16'hffff
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Restore from saved copy
  input  wire logic              loadEn,
  input  wire logic              loadValid,
  input  wire logic [DATA_W-1:0] loadValue,
  // Local port write (priority)
  input  wire logic              wrA,
  input  wire logic [DATA_W-1:0] dataA,
  // Field bus port write
  input  wire logic              wrB,
  input  wire logic [DATA_W-1:0] dataB,
  // Active value and save strobe
  output logic      [DATA_W-1:0] value_q,
  output logic                   commit_q
);
  if (DEF < MINV || DEF > MAXV)
  begin : g_bad_default
    $error("dpr_cfg_word: default outside legal range");
  end

  function automatic logic legal(logic [DATA_W-1:0] v);
    legal = (v >= MINV) && (v <= MAXV);                    // [RULE15] [RULE16]
  endfunction

  // Range check alone keeps the station upper byte clear
  wire logic takeA    = wrA && legal(dataA);    // [RULE12] [RULE13] [RULE17]
  wire logic takeB    = wrB && legal(dataB) && !takeA;     // [RULE14]
  wire logic takeLoad = loadEn && loadValid && legal(loadValue); // [RULE7]
  wire logic [DATA_W-1:0] value_d = takeA ? dataA :
                                    takeB ? dataB :
                                    takeLoad ? loadValue : value_q; // [RULE8]

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      value_q  <= DEF;                                     // [RULE11]
      commit_q <= 1'b0;
    end
    else
    begin
      value_q  <= value_d;
      commit_q <= takeA || takeB;                          // [RULE6]
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_CFG_ILLEGAL_KEEP: assert property ( // [RULE12]
    (wrA && !legal(dataA) && !wrB && !loadEn)
      |=> ($stable(value_q) && !commit_q))
    else $error("illegal config write changed the word");
  AST_CFG_IMMEDIATE: assert property ( // [RULE8]
    (wrA && legal(dataA)) |=> (value_q == $past(dataA) && commit_q))
    else $error("legal config write not applied next cycle");
  AST_CFG_PRIORITY: assert property ( // [RULE14]
    (wrA && wrB && legal(dataA) && legal(dataB)) |=> value_q == $past(dataA))
    else $error("local port did not win a config write clash");
  AST_CFG_IN_RANGE: assert property ( // [RULE15] [RULE16] [RULE17]
    value_q >= MINV && value_q <= MAXV)
    else $error("config word left its legal range");
endmodule : dpr_cfg_word
`default_nettype wire

/* File: hw/dpr_register_store.sv */
// Dual-port 504-word register store with saved configuration words
// What this block does
// RULE1 - One flat page of 504 words, addresses 0 to 503, all served.
// RULE2 - Every word is 16 bits, readable and writable from both ports.
// RULE3 - Single words or back-to-back blocks served on both ports.
// RULE4 - Words 0 to 499 are volatile holding words.
// RULE5 - Holding words take any 16-bit value and start at zero.
// RULE6 - An accepted configuration write also strobes the saved copy.
// RULE7 - After reset configuration loads from the saved copy when present.
// RULE8 - Configuration writes change the active line settings at once.
// RULE9 - Same address, same word on both ports; 500 to 503 configuration.
// RULE10 - Station word is the field bus address recognised as own.
// RULE11 - Station word defaults to one when nothing is saved.
// RULE12 - Station writes outside 1 to 247 change nothing.
// RULE13 - Station word uses bits 7 to 0; upper byte reads zero.
// RULE14 - Same-cycle clash on one word: local port wins, whole word stored. A config word takes the field bus value if the local value is out of range.
// RULE15 - Line speed defaults 113; only codes 110 to 115 accepted.
// RULE16 - Parity codes 120 none, 121 odd, 122 even; default 122.
// RULE17 - Stop bits accept 131 or 132 only; default 131.
// RULE18 - Local serial target answers at seven-bit address 17.
`timescale 1ns/1ps
`default_nettype none
module dpr_register_store
  import dpr_pkg::*;
#(
  parameter int unsigned HOLD_WORDS = HOLD_COUNT
)
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  // Local microcontroller word port
  input  wire logic                        i2cReq,
  input  wire logic                        i2cWrite,
  input  wire logic [ADDR_W-1:0]           i2cAddr,
  input  wire logic [DATA_W-1:0]           i2cWdata,
  output logic                             i2cReady_q,
  output logic                             i2cRvalid_q,
  output logic      [DATA_W-1:0]           i2cRdata_q,
  // Local target address check
  input  wire logic [6:0]                  i2cTargetAddr,
  output logic                             i2cAddrHit_q,
  // Field bus master word port
  input  wire logic                        mbReq,
  input  wire logic                        mbWrite,
  input  wire logic [ADDR_W-1:0]           mbAddr,
  input  wire logic [DATA_W-1:0]           mbWdata,
  output logic                             mbReady_q,
  output logic                             mbRvalid_q,
  output logic      [DATA_W-1:0]           mbRdata_q,
  // Field bus station address check
  input  wire logic [7:0]                  frameStation,
  output logic                             stationMatch_q,
  // Saved configuration copy
  input  wire logic [CFG_COUNT-1:0]        nvSavedValid,
  input  wire logic [CFG_COUNT-1:0][DATA_W-1:0] nvSavedWords,
  output logic      [CFG_COUNT-1:0]        nvSaveEn,
  // Active line settings
  output logic      [DATA_W-1:0]           stationIdent,
  output logic      [DATA_W-1:0]           lineSpeedSel,
  output logic      [DATA_W-1:0]           paritySel,
  output logic      [DATA_W-1:0]           stopBitSel
);
  if (HOLD_WORDS == 0 || HOLD_WORDS > int'(STATION_OFS))
  begin : g_bad_depth
    $error("dpr_register_store: holding words overlap configuration");
  end

  typedef enum logic [2:0]
  {
    ST_LOAD  = 3'b001,
    ST_CLEAR = 3'b010,
    ST_RUN   = 3'b100
  } dpr_state_t;

  dpr_state_t        state_q;
  dpr_state_t        state_d;
  logic [ADDR_W-1:0] clearIdx_q;
  logic [DATA_W-1:0] mem [HOLD_WORDS];
  logic [DATA_W-1:0] cfgVal [CFG_COUNT];
  logic [CFG_COUNT-1:0] cfgCommit;

  localparam logic [ADDR_W-1:0] CLEAR_LAST = ADDR_W'(HOLD_WORDS - 1);

  function automatic logic isHold(logic [ADDR_W-1:0] a);
    isHold = a <= CLEAR_LAST;                              // [RULE4]
  endfunction

  function automatic logic [CFG_COUNT-1:0] cfgHit(logic [ADDR_W-1:0] a);
    cfgHit = {a == STOP_OFS, a == PARITY_OFS,
              a == SPEED_OFS, a == STATION_OFS};           // [RULE9]
  endfunction

  // Words passed in so the selection follows every config update
  function automatic logic [DATA_W-1:0] cfgRead(
    logic [CFG_COUNT-1:0] h,
    logic [DATA_W-1:0]    w [CFG_COUNT]
  );
    cfgRead = READ_NONE;
    for (int k = 0; k < CFG_COUNT; k++)
      if (h[k])
        cfgRead = w[k];
  endfunction

  // Requests wait for the zero sweep so no stale word is ever seen
  wire logic running  = (state_q == ST_RUN);
  wire logic i2cTake  = i2cReq && running;                 // [RULE3]
  wire logic mbTake   = mbReq && running;                  // [RULE3]
  wire logic i2cWr    = i2cTake && i2cWrite;
  wire logic mbWr     = mbTake && mbWrite;
  wire logic i2cHoldWr = i2cWr && isHold(i2cAddr);
  wire logic mbHoldWr  = mbWr && isHold(mbAddr) &&
                         !(i2cHoldWr && i2cAddr == mbAddr); // [RULE14]
  wire logic [CFG_COUNT-1:0] i2cCfgWr = {CFG_COUNT{i2cWr}} & cfgHit(i2cAddr);
  wire logic [CFG_COUNT-1:0] mbCfgWr  = {CFG_COUNT{mbWr}} & cfgHit(mbAddr);
  wire logic loadNow = (state_q == ST_LOAD);

  // Addresses past the page read zero and swallow writes
  wire logic [DATA_W-1:0] i2cRdSel =                       // [RULE1] [RULE2]
    isHold(i2cAddr) ? mem[i2cAddr] : cfgRead(cfgHit(i2cAddr), cfgVal);
  wire logic [DATA_W-1:0] mbRdSel  =                       // [RULE9]
    isHold(mbAddr) ? mem[mbAddr] : cfgRead(cfgHit(mbAddr), cfgVal);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD:  state_d = ST_CLEAR;
      ST_CLEAR: if (clearIdx_q == CLEAR_LAST) state_d = ST_RUN;
      ST_RUN:   state_d = ST_RUN;
      default:  state_d = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q    <= ST_LOAD;
      clearIdx_q <= '0;
    end
    else
    begin
      state_q    <= state_d;
      clearIdx_q <= (state_q == ST_CLEAR) ? clearIdx_q + 1'b1 : '0;
    end
  end

  // Array is cleared by a sweep, too wide for a reset tree
  always_ff @(posedge clk_sys)
  begin
    if (state_q == ST_CLEAR)
      mem[clearIdx_q] <= HOLD_RESET;                       // [RULE5]
    else
    begin
      if (i2cHoldWr)
        mem[i2cAddr] <= i2cWdata;                          // [RULE2]
      if (mbHoldWr)
        mem[mbAddr] <= mbWdata;                            // [RULE14]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      i2cReady_q     <= 1'b0;
      mbReady_q      <= 1'b0;
      i2cRvalid_q    <= 1'b0;
      mbRvalid_q     <= 1'b0;
      i2cRdata_q     <= READ_NONE;
      mbRdata_q      <= READ_NONE;
      stationMatch_q <= 1'b0;
      i2cAddrHit_q   <= 1'b0;
    end
    else
    begin
      i2cReady_q     <= (state_d == ST_RUN);
      mbReady_q      <= (state_d == ST_RUN);
      i2cRvalid_q    <= i2cTake && !i2cWrite;
      mbRvalid_q     <= mbTake && !mbWrite;
      i2cRdata_q     <= (i2cTake && !i2cWrite) ? i2cRdSel : READ_NONE;
      mbRdata_q      <= (mbTake && !mbWrite) ? mbRdSel : READ_NONE;
      stationMatch_q <= frameStation == cfgVal[CFG_STATION][7:0]; // [RULE10]
      i2cAddrHit_q   <= i2cTargetAddr == I2C_TARGET_ADDR;        // [RULE18]
    end
  end

  for (genvar g = 0; g < CFG_COUNT; g++)
  begin : g_cfg
    dpr_cfg_word #(
      .DEF  (CFG_DEF[g]),
      .MINV (CFG_MIN[g]),
      .MAXV (CFG_MAX[g])
    ) u_word (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .loadEn    (loadNow),
      .loadValid (nvSavedValid[g]),
      .loadValue (nvSavedWords[g]),
      .wrA       (i2cCfgWr[g]),
      .dataA     (i2cWdata),
      .wrB       (mbCfgWr[g]),
      .dataB     (mbWdata),
      .value_q   (cfgVal[g]),
      .commit_q  (cfgCommit[g])
    );
  end

  assign nvSaveEn     = cfgCommit;                         // [RULE6]
  assign stationIdent = cfgVal[CFG_STATION];
  assign lineSpeedSel = cfgVal[CFG_SPEED];
  assign paritySel    = cfgVal[CFG_PARITY];
  assign stopBitSel   = cfgVal[CFG_STOP];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_hold_write;
    i2cHoldWr && !mbHoldWr;
  endsequence
  sequence s_read_back;
    i2cTake && !i2cWrite && i2cAddr == $past(i2cAddr);
  endsequence

  AST_READ_ANSWER: assert property ( // [RULE3]
    (i2cTake && !i2cWrite) |=> i2cRvalid_q ##1
      (i2cRvalid_q == $past(i2cTake && !i2cWrite)))
    else $error("local read answer missing or late");
  AST_HOLD_READBACK: assert property ( // [RULE2]
    s_hold_write ##1 s_read_back |=> i2cRdata_q == $past(i2cWdata, 2))
    else $error("holding word read back differs from written value");
  AST_CLASH_LOCAL_WINS: assert property ( // [RULE14]
    (i2cHoldWr && mbWr && mbAddr == i2cAddr) ##1 (mbTake && !mbWrite &&
      mbAddr == $past(mbAddr)) |=> mbRdata_q == $past(i2cWdata, 2))
    else $error("field bus write won a same-word clash");
  AST_STATION_UPPER_ZERO: assert property ( // [RULE13]
    stationIdent[15:8] == 8'h00)
    else $error("station word upper byte not zero");
  AST_CLEAR_DONE: assert property ( // [RULE5]
    $rose(running) |-> $past(clearIdx_q) == CLEAR_LAST)
    else $error("ready before every holding word was cleared");
  AST_OUTSIDE_READS_ZERO: assert property ( // [RULE1]
    (mbTake && !mbWrite && mbAddr > LAST_OFS) |=> mbRdata_q == READ_NONE)
    else $error("read past the page returned data");
  AST_CFG_PORTS_AGREE: assert property ( // [RULE9]
    (i2cTake && !i2cWrite && mbTake && !mbWrite && i2cAddr == mbAddr)
      |=> i2cRdata_q == mbRdata_q)
    else $error("ports read different words at one address");
  AST_SAVE_ON_ACCEPT: assert property ( // [RULE6]
    (i2cWr && i2cAddr == STATION_OFS && i2cWdata == 16'h0005)
      |=> nvSaveEn[CFG_STATION] && stationIdent == 16'h0005)
    else $error("accepted station write not saved");
  AST_TARGET_HIT: assert property ( // [RULE18]
    (i2cTargetAddr == I2C_TARGET_ADDR) |=> i2cAddrHit_q)
    else $error("target address 17 not recognised");
endmodule : dpr_register_store
`default_nettype wire

/* File: tb/dpr_nv_model.sv */
// Behavioural saved-copy store behind the configuration words
`timescale 1ns/1ps
`default_nettype none
module dpr_nv_model
  import dpr_pkg::*;
(
  // Clock
  input  wire logic                             clk_sys,
  // Save strobes and live words
  input  wire logic [CFG_COUNT-1:0]             nvSaveEn,
  input  wire logic [CFG_COUNT-1:0][DATA_W-1:0] liveWords,
  // Saved copy, survives any reset
  output logic      [CFG_COUNT-1:0]             nvSavedValid,
  output logic      [CFG_COUNT-1:0][DATA_W-1:0] nvSavedWords
);
  // Empty at power-up, so the device must start from defaults
  initial
  begin
    nvSavedValid = '0;
    nvSavedWords = '0;
    forever
    begin
      @(posedge clk_sys);
      for (int i = 0; i < CFG_COUNT; i++)
        if (nvSaveEn[i])
        begin
          nvSavedValid[i] <= 1'b1;
          nvSavedWords[i] <= liveWords[i];
        end
    end
  end
endmodule // dpr_nv_model
`default_nettype wire

/* File: tb/dual_port_modbus_register_map_test.sv */
// Self-checking bench for the dual-port register store
`timescale 1ns/1ps
`default_nettype none
module dual_port_modbus_register_map_test;
  import dpr_pkg::*;
  localparam int LO [4] = '{1, 110, 120, 131};
  localparam int HI [4] = '{247, 115, 122, 132};
  logic        clk_sys = 1'b0, reset_n = 1'b0;
  logic        i2cReq = 1'b0, i2cWrite = 1'b0, mbReq = 1'b0, mbWrite = 1'b0;
  logic [8:0]  i2cAddr = '0, mbAddr = '0;
  logic [15:0] i2cWdata = '0, mbWdata = '0;
  logic [6:0]  i2cTargetAddr = '0;
  logic [7:0]  frameStation = '0;
  logic        i2cReady_q, i2cRvalid_q, i2cAddrHit_q, stationMatch_q;
  logic        mbReady_q, mbRvalid_q;
  logic [15:0] i2cRdata_q, mbRdata_q, stationIdent, lineSpeedSel;
  logic [15:0] paritySel, stopBitSel;
  logic [3:0]  nvSavedValid, nvSaveEn;
  logic [3:0][15:0] nvSavedWords;
  logic [15:0] mem [504];
  logic [31:0] seed = 32'h9332114b;
  int          n_errors = 0, samples_checked = 0, cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  dpr_register_store #(.HOLD_WORDS(HOLD_COUNT)) dut_u (.clk_sys(clk_sys),
    .reset_n(reset_n), .i2cReq(i2cReq), .i2cWrite(i2cWrite),
    .i2cAddr(i2cAddr), .i2cWdata(i2cWdata), .i2cReady_q(i2cReady_q),
    .i2cRvalid_q(i2cRvalid_q), .i2cRdata_q(i2cRdata_q),
    .i2cTargetAddr(i2cTargetAddr), .i2cAddrHit_q(i2cAddrHit_q),
    .mbReq(mbReq), .mbWrite(mbWrite), .mbAddr(mbAddr), .mbWdata(mbWdata),
    .mbReady_q(mbReady_q), .mbRvalid_q(mbRvalid_q), .mbRdata_q(mbRdata_q),
    .frameStation(frameStation), .stationMatch_q(stationMatch_q),
    .nvSavedValid(nvSavedValid), .nvSavedWords(nvSavedWords),
    .nvSaveEn(nvSaveEn), .stationIdent(stationIdent),
    .lineSpeedSel(lineSpeedSel), .paritySel(paritySel),
    .stopBitSel(stopBitSel));

  dpr_nv_model nv_u (.clk_sys(clk_sys), .nvSaveEn(nvSaveEn),
    .liveWords({stopBitSel, paritySel, lineSpeedSel, stationIdent}),
    .nvSavedValid(nvSavedValid), .nvSavedWords(nvSavedWords));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic bit ok(input logic [8:0] a, input logic [15:0] d);
    return int'(d) >= LO[a[1:0]] && int'(d) <= HI[a[1:0]];
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    i2cReq = 1'b0;
    mbReq = 1'b0;
    reset_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    for (int k = 0; k < 500; k++)
      mem[k] = 16'h0000;
    // Poll off the edge so ready is read once it has settled
    for (int k = 0; k < 1000 && i2cReady_q !== 1'b1; k++)
      #5;
    @(posedge clk_sys);
    #1;
    chk({14'h0, i2cReady_q, mbReady_q}, 16'h3);
  endtask

  // Requests stay up between calls so consecutive calls are back to back
  task automatic op(input bit p, input bit w, input logic [8:0] a,
                    input logic [15:0] d);
    logic [15:0] e;
    logic [3:0]  s;
    e = (a < 504) ? mem[a] : 16'h0000;
    s = 4'h0;
    if (p)
    begin
      mbReq = 1'b1;
      mbWrite = w;
      mbAddr = a;
      mbWdata = d;
      i2cReq = 1'b0;
    end
    else
    begin
      i2cReq = 1'b1;
      i2cWrite = w;
      i2cAddr = a;
      i2cWdata = d;
      mbReq = 1'b0;
    end
    if (w && a < 500)
      mem[a] = d;
    else if (w && a < 504 && ok(a, d))
    begin
      mem[a] = d;
      s[a[1:0]] = 1'b1;
    end
    @(posedge clk_sys);
    #1;
    if (!w)
    begin
      chk({15'h0, p ? mbRvalid_q : i2cRvalid_q}, 16'h1);
      chk(p ? mbRdata_q : i2cRdata_q, e);
    end
    chk({12'h0, nvSaveEn}, {12'h0, s});
    chk(stationIdent, mem[500]);
    chk(lineSpeedSel, mem[501]);
    chk(paritySel, mem[502]);
    chk(stopBitSel, mem[503]);
  endtask

  task automatic clash(input logic [8:0] a, input logic [15:0] di, dm);
    i2cReq = 1'b1;
    i2cWrite = 1'b1;
    i2cAddr = a;
    i2cWdata = di;
    mbReq = 1'b1;
    mbWrite = 1'b1;
    mbAddr = a;
    mbWdata = dm;
    if (a < 500 || ok(a, di))
      mem[a] = di;
    else if (ok(a, dm))
      mem[a] = dm;
    @(posedge clk_sys);
    #1;
    op(1'b1, 1'b0, a, 16'h0);
  endtask

  // Both ports read one word in the same cycle
  task automatic both_rd(input logic [8:0] a);
    i2cReq = 1'b1;
    i2cWrite = 1'b0;
    i2cAddr = a;
    mbReq = 1'b1;
    mbWrite = 1'b0;
    mbAddr = a;
    @(posedge clk_sys);
    #1;
    chk(i2cRdata_q, mem[a]);
    chk(mbRdata_q, mem[a]);
  endtask

  task automatic addr_chk(input logic [7:0] fs, input logic [6:0] ta,
                          input logic [15:0] exp);
    frameStation = fs;
    i2cTargetAddr = ta;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({14'h0, stationMatch_q, i2cAddrHit_q}, exp);
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [8:0]  a;
    mem[500] = 16'h0001;
    mem[501] = 16'h0071;
    mem[502] = 16'h007a;
    mem[503] = 16'h0083;
    do_reset();
    for (int k = 0; k < 60; k++)
    begin
      r = rnd();
      a = 9'(r[24:16] % 500);
      op(r[31], 1'b1, a, k < 2 ? {16{k[0]}} : r[15:0]);
      op(r[30], 1'b0, a, 16'h0);
    end
    for (int k = 496; k < 500; k++)
      op(1'b1, 1'b1, k[8:0], 16'hffff - k[15:0]);
    op(1'b0, 1'b1, 9'd504, 16'h1234);
    for (int k = 496; k < 506; k++)
      op(k[0], 1'b0, k[8:0], 16'h0);
    for (int i = 1; i < 4; i++)
      for (int v = LO[i] - 1; v <= HI[i] + 1; v++)
        op(v[0], 1'b1, 9'(500 + i), v[15:0]);
    op(1'b0, 1'b1, 9'd502, 16'h0079);
    foreach (LO[i])
      op(i[0], 1'b1, 9'd500, 16'(LO[i] + 100 * i));
    op(1'b1, 1'b1, 9'd500, 16'h0105);
    op(1'b0, 1'b1, 9'd500, 16'h0005);
    op(1'b0, 1'b1, 9'd500, 16'(1 + rnd() % 247));
    clash(9'd7, 16'h1111, 16'h2222);
    clash(9'd500, 16'h0000, 16'h0009);
    both_rd(9'd7);
    both_rd(9'd500);
    addr_chk(mem[500][7:0], 7'h11, 16'h3);
    addr_chk(mem[500][7:0] ^ 8'h80, 7'h10, 16'h0);
    do_reset();
    for (int k = 496; k < 504; k++)
      op(k[0], 1'b0, k[8:0], 16'h0);
    op(1'b0, 1'b0, 9'd7, 16'h0);
    report_and_stop();
  end
endmodule // dual_port_modbus_register_map_test
`default_nettype wire
